//--- rtl/clt_pkg.sv
// Constants and carrier types for the codec serial port with loop-back and DC-blocking filter.
// Assumes a single 125 MHz system clock; the serial bit clock arrives as a sampled input.
// What this block does
// - Loop-back high: ADC words feed the DAC.
// - Loop-back low: serial input words feed DAC.
// - Serial port keeps running during loop-back.
// - Bypass high: ADC samples keep DC.
// - Frame sync sampled on rising bit clock.
// - Serial input captured on rising bit clock.
// - Serial output changes on falling bit clock.
// - Slot mode: serial output released when own slot ends.
// - Frame sync out launched on falling edge.
// - Frame sync out high one bit period.
// - Slot mode: frame is 64 bits, four 16-bit slots; otherwise 16 bits.
// - Slot mode drives frame sync to next codec.
// - Slot mode latched only at reset or wake.
// - Words are 16-bit two's complement, MSB first.
package clt_pkg;
    localparam int WORD_BITS    = 16;
    localparam int SLOT_COUNT   = 4;
    localparam int FRAME_BITS   = WORD_BITS * SLOT_COUNT;
    localparam int BIT_CNT_W    = 6;
    localparam int HPF_SHIFT    = 8;
    localparam int FIFO_DEPTH   = 8;
    localparam logic [15:0] WORD_RESET = 16'h0000;

    typedef logic signed [WORD_BITS-1:0] clt_word_t;

    typedef struct packed {
        logic loopback_select;
        logic highpass_bypass;
    } clt_mode_s;

    typedef struct packed {
        logic data;
        logic oe;
    } clt_pin_s;
endpackage

//--- rtl/clt_fifo.sv
// Small flip-flop FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none
module clt_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
    logic [AW:0]      cnt_q, cnt_d;
    logic             push, pop;

    assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem_q[rd_q];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        wr_d  = push ? AW'(wr_q + 1'b1) : wr_q;
        rd_d  = pop ? AW'(rd_q + 1'b1) : rd_q;
        cnt_d = cnt_q;
        if (push && !pop) begin
            cnt_d = cnt_q + 1'b1;
        end else if (pop && !push) begin
            cnt_d = cnt_q - 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            wr_q  <= wr_d;
            rd_q  <= rd_d;
            cnt_q <= cnt_d;
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end
endmodule
`default_nettype wire

//--- rtl/clt_port.sv
// Serial port, time-slot framing, loop-back select and DC-blocking filter of a mono codec.
// Assumes bit_clock, frame_sync and serial_in come from the host domain and are sampled here.
`timescale 1ns/100ps
`default_nettype none
module clt_port
    import clt_pkg::*;
#(
    parameter int SLOT_COUNT_P = clt_pkg::SLOT_COUNT
) (
    input  wire logic               clk,
    input  wire logic               rst,
    input  wire logic               bit_clock,
    input  wire logic               frame_sync,
    input  wire logic               serial_in,
    input  wire logic               power_down_n,
    input  wire logic               slot_mode_select,
    input  wire clt_pkg::clt_mode_s mode,
    input  wire clt_pkg::clt_word_t adc_word,
    input  wire logic               adc_valid,
    output logic                    adc_ready,
    output clt_pkg::clt_word_t      dac_word,
    output logic                    dac_valid,
    output logic                    serial_out,
    output logic                    serial_out_oe,
    output logic                    frame_sync_out,
    output logic                    slot_mode
);
    import clt_pkg::*;

    // Three-stage synchronisers; a change counts once stages two and three agree.
    logic [2:0] bck_s_q, fs_s_q, din_s_q, pdn_s_q;
    logic       bck_q, fs_q, din_q, pdn_q;
    always_ff @(posedge clk) begin
        if (rst) begin
            bck_s_q <= '0;
            fs_s_q  <= '0;
            din_s_q <= '0;
            // The power-down pin idles high; starting low would fake a wake-up edge after reset.
            pdn_s_q <= '1;
            bck_q   <= 1'b0;
            fs_q    <= 1'b0;
            din_q   <= 1'b0;
            pdn_q   <= 1'b1;
        end else begin
            bck_s_q <= {bck_s_q[1:0], bit_clock};
            fs_s_q  <= {fs_s_q[1:0], frame_sync};
            din_s_q <= {din_s_q[1:0], serial_in};
            pdn_s_q <= {pdn_s_q[1:0], power_down_n};
            if (bck_s_q[1] == bck_s_q[2]) bck_q <= bck_s_q[2];
            if (fs_s_q[1] == fs_s_q[2]) fs_q <= fs_s_q[2];
            if (din_s_q[1] == din_s_q[2]) din_q <= din_s_q[2];
            if (pdn_s_q[1] == pdn_s_q[2]) pdn_q <= pdn_s_q[2];
        end
    end

    logic bck_prev_q, pdn_prev_q, bck_rise, bck_fall, pdn_rise;
    assign bck_rise = bck_q && !bck_prev_q;
    assign bck_fall = !bck_q && bck_prev_q;
    assign pdn_rise = pdn_q && !pdn_prev_q;

    // Slot mode is caught after reset release and on each wake-up edge only.
    logic slot_mode_q, slot_mode_d, latch_pend_q;
    always_comb begin
        slot_mode_d = slot_mode_q;
        if (latch_pend_q || pdn_rise) slot_mode_d = slot_mode_select;
    end

    // Framing state, updated on bit clock edges.
    logic [BIT_CNT_W-1:0] bit_cnt_q, bit_cnt_d;
    logic                 synced_q, synced_d;
    clt_word_t            rx_sh_q, rx_sh_d, tx_sh_q, tx_sh_d;
    clt_word_t            dac_q, dac_d, adc_hold_q, adc_hold_d;
    logic                 dac_v_q, dac_v_d, so_q, so_d, oe_q, oe_d, fso_q, fso_d;
    logic                 word_end, slot_last, in_own, slot_done;
    logic [BIT_CNT_W-1:0] frame_last;

    assign frame_last = slot_mode_q ? BIT_CNT_W'(WORD_BITS * SLOT_COUNT_P - 1) : BIT_CNT_W'(WORD_BITS - 1);
    assign word_end   = (bit_cnt_q[3:0] == 4'hf);
    assign in_own     = (bit_cnt_q < BIT_CNT_W'(WORD_BITS));
    assign slot_last  = (bit_cnt_q == BIT_CNT_W'(WORD_BITS - 1));
    assign slot_done  = (bit_cnt_q == BIT_CNT_W'(WORD_BITS));

    // DC-blocking filter: y = x - dc, dc tracks the running mean.
    logic signed [WORD_BITS+HPF_SHIFT-1:0] dc_q, dc_d;
    logic signed [WORD_BITS:0]             hp_full;
    clt_word_t                             hp_word, adc_filt;
    assign hp_full  = (WORD_BITS+1)'(adc_word) - (WORD_BITS+1)'($signed(dc_q[WORD_BITS+HPF_SHIFT-1:HPF_SHIFT]));
    assign hp_word  = (hp_full > 17'sh07fff) ? 16'sh7fff :
                      (hp_full < -17'sh08000) ? -16'sh8000 : hp_full[WORD_BITS-1:0];
    assign adc_filt = mode.highpass_bypass ? adc_word : hp_word;

    logic fifo_in_ready, fifo_out_valid, fifo_pop;
    clt_word_t fifo_out;
    assign adc_ready = fifo_in_ready;
    assign fifo_pop  = fifo_out_valid && bck_fall && synced_q && slot_last;

    clt_fifo #(.WIDTH(WORD_BITS), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk       (clk),
        .rst       (rst),
        .in_data   (adc_filt),
        .in_valid  (adc_valid),
        .in_ready  (fifo_in_ready),
        .out_data  (fifo_out),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_pop)
    );

    always_comb begin
        dc_d = dc_q;
        if (adc_valid && fifo_in_ready) begin
            dc_d = dc_q + (WORD_BITS+HPF_SHIFT)'(hp_word);
        end
        bit_cnt_d  = bit_cnt_q;
        synced_d   = synced_q;
        rx_sh_d    = rx_sh_q;
        tx_sh_d    = tx_sh_q;
        dac_d      = dac_q;
        dac_v_d    = 1'b0;
        adc_hold_d = fifo_pop ? fifo_out : adc_hold_q;
        so_d       = so_q;
        oe_d       = oe_q;
        fso_d      = fso_q;
        if (bck_rise) begin
            rx_sh_d = {rx_sh_q[WORD_BITS-2:0], din_q};
            if (fs_q) begin
                bit_cnt_d = '0;
                synced_d  = 1'b1;
            end else if (synced_q) begin
                bit_cnt_d = (bit_cnt_q == frame_last) ? '0 : BIT_CNT_W'(bit_cnt_q + 1'b1);
            end
            if (synced_q && in_own && word_end) begin
                dac_v_d = 1'b1;
                // Loop-back replaces the received word; the shifter still runs.
                dac_d = mode.loopback_select ? adc_hold_q : {rx_sh_q[WORD_BITS-2:0], din_q};
            end
        end
        if (bck_fall && synced_q) begin
            if (bit_cnt_q == '0) begin
                tx_sh_d = {adc_hold_q[WORD_BITS-2:0], 1'b0};
                so_d    = adc_hold_q[WORD_BITS-1];
                oe_d    = 1'b1;
            end else if (in_own) begin
                so_d    = tx_sh_q[WORD_BITS-1];
                tx_sh_d = {tx_sh_q[WORD_BITS-2:0], 1'b0};
            end else if (slot_done) begin
                // The LSB has had its full bit period; free the shared line for the next slot.
                oe_d = 1'b0;
                so_d = 1'b0;
            end
            fso_d = slot_mode_q && slot_last;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            bck_prev_q   <= 1'b0;
            pdn_prev_q   <= 1'b0;
            latch_pend_q <= 1'b1;
            slot_mode_q  <= 1'b0;
            bit_cnt_q    <= '0;
            synced_q     <= 1'b0;
            rx_sh_q      <= WORD_RESET;
            tx_sh_q      <= WORD_RESET;
            dac_q        <= WORD_RESET;
            adc_hold_q   <= WORD_RESET;
            dac_v_q      <= 1'b0;
            so_q         <= 1'b0;
            oe_q         <= 1'b0;
            fso_q        <= 1'b0;
            dc_q         <= '0;
        end else begin
            bck_prev_q   <= bck_q;
            pdn_prev_q   <= pdn_q;
            latch_pend_q <= 1'b0;
            slot_mode_q  <= slot_mode_d;
            bit_cnt_q    <= bit_cnt_d;
            synced_q     <= synced_d;
            rx_sh_q      <= rx_sh_d;
            tx_sh_q      <= tx_sh_d;
            dac_q        <= dac_d;
            adc_hold_q   <= adc_hold_d;
            dac_v_q      <= dac_v_d;
            so_q         <= so_d;
            oe_q         <= oe_d;
            fso_q        <= fso_d;
            dc_q         <= dc_d;
        end
    end

    assign dac_word       = dac_q;
    assign dac_valid      = dac_v_q;
    assign serial_out     = so_q;
    assign serial_out_oe  = oe_q;
    assign frame_sync_out = fso_q;
    assign slot_mode      = slot_mode_q;

    // Checks.
    a_out_on_fall: assert property (@(posedge clk) disable iff (rst)
        $changed(serial_out) |-> $past(bck_fall)) else $error("serial_out moved off a falling edge");
    a_fso_on_fall: assert property (@(posedge clk) disable iff (rst)
        $rose(frame_sync_out) |-> $past(bck_fall) && slot_mode) else $error("frame_sync_out bad launch");
    a_oe_release: assert property (@(posedge clk) disable iff (rst)
        $fell(serial_out_oe) |-> $past(bck_fall && slot_done)) else $error("serial_out not released at slot end");
    a_fso_mode: assert property (@(posedge clk) disable iff (rst)
        frame_sync_out |-> slot_mode) else $error("frame_sync_out outside slot mode");
    a_loop_word: assert property (@(posedge clk) disable iff (rst)
        dac_valid && mode.loopback_select && $past(mode.loopback_select) |-> dac_word == $past(adc_hold_q))
        else $error("loop-back word not taken from ADC");
    a_norm_word: assert property (@(posedge clk) disable iff (rst)
        dac_valid && !$past(mode.loopback_select) |-> dac_word == $past({rx_sh_q[14:0], din_q}))
        else $error("received word not passed to DAC");
    a_bypass_path: assert property (@(posedge clk) disable iff (rst)
        mode.highpass_bypass |-> adc_filt == adc_word) else $error("bypass altered ADC sample");
    a_slot_hold: assert property (@(posedge clk) disable iff (rst)
        !pdn_rise && !latch_pend_q |=> $stable(slot_mode)) else $error("slot mode changed off wake");
    a_frame_wrap: assert property (@(posedge clk) disable iff (rst)
        bck_rise && synced_q && bit_cnt_q == frame_last |=> bit_cnt_q == '0)
        else $error("frame length wrong");
endmodule
`default_nettype wire

//--- test/clt_host.sv
// Behavioural host serial port facing the codec port: makes bit clock and frame sync.
// Assumes the bench resolves the output line and that the clock stands still while run is low.
`timescale 1ns/100ps
`default_nettype none
module clt_host (
    input  wire logic               run,
    input  wire logic [6:0]         frame_bits,
    input  wire clt_pkg::clt_word_t tx_word,
    input  wire logic               line,
    input  wire logic               line_oe,
    output logic                    bit_clock,
    output logic                    frame_sync,
    output logic                    serial_in,
    output clt_pkg::clt_word_t      rx_word,
    output int                      frames
);
    import clt_pkg::*;
    logic [15:0] sh;
    int          b;
    initial begin
        bit_clock = 1'b0;
        frame_sync = 1'b0;
        serial_in = 1'b0;
        rx_word = '0;
        frames = 0;
        sh = '0;
        #5.3;
        forever begin
            if (!run) begin
                frame_sync = 1'b0;
                wait (run);
                frame_sync = 1'b1;
                #32 bit_clock = 1'b1;
                #32 bit_clock = 1'b0;
            end
            for (b = 0; b < int'(frame_bits); b++) begin
                frame_sync = (b == int'(frame_bits) - 1);
                // Outside the word the line toggles so a stale bit is never mistaken for data.
                serial_in = (b < WORD_BITS) ? tx_word[WORD_BITS-1-b] : ~serial_in;
                #32 bit_clock = 1'b1;
                #31 if (line_oe) sh = {sh[14:0], line};
                #1 bit_clock = 1'b0;
            end
            rx_word = sh;
            frames++;
        end
    end
endmodule
`default_nettype wire

//--- test/codec_loopback_hpf_tdm_port_tb.sv
// Self-checking bench for the codec serial port with loop-back and DC-blocking filter.
// Assumes the host model drives the serial side at a 64 ns bit period.
`timescale 1ns/100ps
`default_nettype none
module codec_loopback_hpf_tdm_port_tb;
    import clt_pkg::*;
    logic       clk = 0, rst = 1, power_down_n = 1, slot_mode_select = 0, adc_valid = 0, run = 0;
    clt_mode_s  mode = '0;
    clt_word_t  adc_word = '0, tx_word = '0, dac_word, rx_word;
    logic [6:0] frame_bits = 7'h10;
    logic       adc_ready, dac_valid, serial_out, serial_out_oe, frame_sync_out, slot_mode;
    logic       bit_clock, frame_sync, serial_in;
    int         frames, fail_count = 0, samples_checked = 0;
    always #4 clk = ~clk;
    clt_port dut (.clk(clk), .rst(rst), .bit_clock(bit_clock), .frame_sync(frame_sync), .serial_in(serial_in),
        .power_down_n(power_down_n), .slot_mode_select(slot_mode_select), .mode(mode), .adc_word(adc_word),
        .adc_valid(adc_valid), .adc_ready(adc_ready), .dac_word(dac_word), .dac_valid(dac_valid),
        .serial_out(serial_out), .serial_out_oe(serial_out_oe), .frame_sync_out(frame_sync_out),
        .slot_mode(slot_mode));
    clt_host host (.run(run), .frame_bits(frame_bits), .tx_word(tx_word), .line(serial_out),
        .line_oe(serial_out_oe), .bit_clock(bit_clock), .frame_sync(frame_sync), .serial_in(serial_in),
        .rx_word(rx_word), .frames(frames));
    task automatic check_word(string what, clt_word_t exp, clt_word_t got);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic check_flag(string what, logic exp, logic got);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic check_count(string what, int exp, int got);
        samples_checked++;
        if (got != exp) begin
            fail_count++;
            $display("mismatch %s expected %0d seen %0d", what, exp, got);
        end
    endtask
    task automatic wait_frames(int n);
        int f0;
        f0 = frames;
        wait (frames >= f0 + n);
        @(posedge clk);
    endtask
    task automatic t_fifo;
        int n, i;
        logic acc;
        clt_word_t q[$];
        n = 0;
        @(posedge clk);
        adc_word <= 16'h1234;
        adc_valid <= 1'b1;
        mode <= clt_mode_s'(2'b01);
        for (i = 0; i < 12; i++) begin
            @(negedge clk) acc = adc_ready;
            @(posedge clk);
            if (acc) begin
                n++;
                adc_word <= clt_word_t'(16'h1234 * (n + 1));
            end
        end
        adc_valid <= 1'b0;
        check_count("words taken before refusal", FIFO_DEPTH, n);
        run <= 1'b1;
        for (i = 0; i < 12; i++) begin
            wait_frames(1);
            if (q.size() > 0 || rx_word !== 16'h0000) q.push_back(rx_word);
        end
        for (i = 1; i <= FIFO_DEPTH; i++) check_word("drained word", clt_word_t'(16'h1234 * i), q[i-1]);
        check_flag("ready after drain", 1'b1, adc_ready);
    endtask
    task automatic t_paths;
        @(posedge clk);
        adc_word <= 16'h2d4b;
        adc_valid <= 1'b1;
        tx_word <= 16'hc35a;
        wait_frames(3);
        check_word("dac from serial input", 16'hc35a, dac_word);
        check_word("host read raw adc", 16'h2d4b, rx_word);
        mode <= clt_mode_s'(2'b11);
        tx_word <= 16'h7001;
        wait_frames(3);
        check_word("dac in loop-back", 16'h2d4b, dac_word);
        check_word("host read in loop-back", 16'h2d4b, rx_word);
        mode <= clt_mode_s'(2'b00);
        adc_word <= 16'h4000;
        wait_frames(40);
        check_flag("filtered below input", 1'b1, rx_word > 0 && rx_word < 16'sh4000);
    endtask
    task automatic relatch(logic sel);
        run <= 1'b0;
        wait_frames(1);
        repeat (20) @(posedge clk);
        slot_mode_select <= sel;
        power_down_n <= 1'b0;
        repeat (4) @(posedge clk);
        power_down_n <= 1'b1;
        repeat (8) @(posedge clk);
        check_flag("slot mode after wake", sel, slot_mode);
    endtask
    task automatic t_slot;
        int f0, nf, no;
        nf = 0;
        no = 0;
        mode <= clt_mode_s'(2'b01);
        adc_word <= 16'h5a3c;
        relatch(1'b1);
        frame_bits <= 7'h40;
        run <= 1'b1;
        // Old filtered words still fill the FIFO; let them drain before judging the slot word.
        wait_frames(FIFO_DEPTH + 2);
        f0 = frames;
        while (frames == f0) begin
            @(negedge clk);
            nf += int'(frame_sync_out);
            no += int'(serial_out_oe);
        end
        check_count("sync out cycles per frame", 8, nf);
        check_count("drive cycles per frame", WORD_BITS * 8, no);
        check_word("slot word", 16'h5a3c, rx_word);
        slot_mode_select <= 1'b0;
        repeat (10) @(posedge clk);
        check_flag("slot mode ignores strap", 1'b1, slot_mode);
        relatch(1'b0);
    endtask
    task automatic wrap_up;
        $display("checks %0d failures %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        #400000;
        fail_count++;
        wrap_up();
    end
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        t_fifo();
        t_paths();
        t_slot();
        wrap_up();
    end
endmodule
`default_nettype wire
